//--- pkg/reader_ctrl_defines.vh
`ifndef READER_CTRL_DEFINES_VH
`define READER_CTRL_DEFINES_VH
`define ADDR_POWER_MODE 8'h00
`define ADDR_PROTOCOL 8'h01
`define POWER_MODE_RESET 8'h01
`define PROTOCOL_RESET 8'h02
`define POWER_MODE_WMASK 8'hfb
`define BIT_STANDBY 7
`define BIT_DIRECT 6
`define BIT_CARRIER 5
`define BIT_HALF_PWR 4
`define BIT_AUX_IN 3
`define BIT_RX_FORCE 1
`define BIT_SUPPLY 0
`define BIT_CRC_ABSENT 7
`define BIT_RAW_TYPE 6
`define BIT_TAG_MODE 5
`define CODE_MSB 4
`define CODE_WIDTH 5
`define FAM_VICINITY 3'h0
`define FAM_TYPE_A 3'h1
`define FAM_TYPE_B 3'h2
`define FAM_HIGH_RATE 3'h3
`define FAM_INVALID 3'h4
`define CODE_A_BASE 5'h08
`define CODE_B_BASE 5'h0c
`define CODE_B_LAST 5'h0f
`define CODE_HR_212 5'h1a
`define CODE_HR_424 5'h1b
`define WAKE_TIME_NS 100000
`define CLOCK_PERIOD_NS 10
`define WAKE_CYCLES ((`WAKE_TIME_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define WAKE_CNT_W 14
`define WAKE_LOAD 14'h2710
`endif

//--- rtl/protocol_decoder.v
`timescale 1ns/100ps
`default_nettype none
`include "reader_ctrl_defines.vh"
module protocol_decoder (
  input wire [4:0] i_code,
  output reg [2:0] o_family,
  output reg [1:0] o_rate
);
  always @* begin
    o_rate = i_code[1:0];
    if (i_code < `CODE_A_BASE) begin
      o_family = `FAM_VICINITY;
    end else if (i_code < `CODE_B_BASE) begin
      o_family = `FAM_TYPE_A;
    end else if (i_code <= `CODE_B_LAST) begin
      o_family = `FAM_TYPE_B;
    end else if (i_code == `CODE_HR_212 || i_code == `CODE_HR_424) begin
      o_family = `FAM_HIGH_RATE;
    end else begin
      o_family = `FAM_INVALID;
    end
  end
endmodule
`default_nettype wire

//--- rtl/reader_main_control_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "reader_ctrl_defines.vh"
module reader_main_control_regs (
  input wire i_clock,
  input wire i_nrst,
  input wire i_enable,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  output reg o_rvalid,
  output reg o_standby,
  output reg o_ready,
  output reg o_direct_mode,
  output reg o_raw_mode_type,
  output reg o_tx_on,
  output reg o_rx_on,
  output reg o_osc_on,
  output reg o_half_power,
  output reg o_aux_rx_sel,
  output reg o_supply_5v,
  output reg o_crc_present,
  output reg [4:0] o_protocol_code,
  output reg [2:0] o_protocol_family,
  output reg [1:0] o_protocol_rate,
  output reg o_option_reload
);
  reg en_meta_reg;
  reg en_sync_reg;
  reg [7:0] power_mode_reg;
  reg [7:0] protocol_reg;
  reg [`WAKE_CNT_W-1:0] wake_cnt_reg;
  wire clear_n;
  wire wr_power;
  wire wr_protocol;
  wire [2:0] family;
  wire [1:0] rate;

  // Enable pin is asynchronous to the clock
  always @(posedge i_clock) begin
    if (!i_nrst) begin
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
    end else begin
      en_meta_reg <= i_enable;
      en_sync_reg <= en_meta_reg;
    end
  end

  assign clear_n = i_nrst & en_sync_reg;
  assign wr_power = i_wr && (i_addr == `ADDR_POWER_MODE);
  assign wr_protocol = i_wr && (i_addr == `ADDR_PROTOCOL);

  always @(posedge i_clock) begin
    if (!clear_n) begin
      power_mode_reg <= `POWER_MODE_RESET;
      protocol_reg <= `PROTOCOL_RESET;
    end else begin
      if (wr_power) begin
        power_mode_reg <= i_wdata & `POWER_MODE_WMASK;
      end
      if (wr_protocol) begin
        protocol_reg <= i_wdata;
      end
    end
  end

  protocol_decoder u_decoder (
    .i_code(protocol_reg[`CODE_MSB:0]),
    .o_family(family),
    .o_rate(rate)
  );

  // Wake timer from standby to full operation
  always @(posedge i_clock) begin
    if (!clear_n) begin
      wake_cnt_reg <= {`WAKE_CNT_W{1'b0}};
    end else if (power_mode_reg[`BIT_STANDBY]) begin
      wake_cnt_reg <= `WAKE_LOAD;
    end else if (wake_cnt_reg != {`WAKE_CNT_W{1'b0}}) begin
      wake_cnt_reg <= wake_cnt_reg - {{(`WAKE_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge i_clock) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
      o_standby <= 1'b0;
      o_ready <= 1'b0;
      o_direct_mode <= 1'b0;
      o_raw_mode_type <= 1'b0;
      o_tx_on <= 1'b0;
      o_rx_on <= 1'b0;
      o_osc_on <= 1'b0;
      o_half_power <= 1'b0;
      o_aux_rx_sel <= 1'b0;
      o_supply_5v <= 1'b0;
      o_crc_present <= 1'b0;
      o_protocol_code <= 5'h00;
      o_protocol_family <= 3'h0;
      o_protocol_rate <= 2'h0;
      o_option_reload <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
      if (i_rd && i_addr == `ADDR_POWER_MODE) begin
        o_rdata <= power_mode_reg;
      end else if (i_rd && i_addr == `ADDR_PROTOCOL) begin
        o_rdata <= protocol_reg;
      end else begin
        o_rdata <= 8'h00;
      end
      o_standby <= power_mode_reg[`BIT_STANDBY];
      o_ready <= clear_n && !power_mode_reg[`BIT_STANDBY] &&
        (wake_cnt_reg == {`WAKE_CNT_W{1'b0}});
      o_direct_mode <= power_mode_reg[`BIT_DIRECT];
      o_raw_mode_type <= protocol_reg[`BIT_RAW_TYPE];
      o_tx_on <= power_mode_reg[`BIT_CARRIER];
      o_rx_on <= power_mode_reg[`BIT_RX_FORCE] | power_mode_reg[`BIT_CARRIER];
      o_osc_on <= power_mode_reg[`BIT_RX_FORCE] | power_mode_reg[`BIT_CARRIER];
      o_half_power <= power_mode_reg[`BIT_HALF_PWR];
      o_aux_rx_sel <= power_mode_reg[`BIT_AUX_IN];
      o_supply_5v <= power_mode_reg[`BIT_SUPPLY];
      o_crc_present <= !protocol_reg[`BIT_CRC_ABSENT];
      o_protocol_code <= protocol_reg[`CODE_MSB:0];
      o_protocol_family <= family;
      o_protocol_rate <= rate;
      o_option_reload <= wr_protocol & clear_n;
    end
  end
endmodule
`default_nettype wire

//--- dv/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic i_clock,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  initial {o_wr, o_rd, o_addr, o_wdata} = 18'h0;
  task automatic access(input logic w, input logic [7:0] a, d);
    @(negedge i_clock);
    {o_wr, o_rd, o_addr} = {w, !w, a};
    o_wdata = (a == 8'h01) ? (d & 8'hdf) : d;
    @(negedge i_clock);
    {o_wr, o_rd, o_addr, o_wdata} = {2'h0, ~a, ~o_wdata};
  endtask
endmodule
`default_nettype wire

//--- dv/ctrl_regs_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module ctrl_regs_monitor (
  input wire logic i_clock, i_nrst, i_enable, i_wr, i_rd,
  input wire logic [7:0] i_addr, i_wdata, o_rdata,
  input wire logic o_rvalid, o_standby, o_ready, o_direct_mode, o_tx_on, o_rx_on, o_osc_on,
  input wire logic o_half_power, o_aux_rx_sel, o_supply_5v, o_crc_present, o_raw_mode_type,
  input wire logic o_option_reload,
  input wire logic [4:0] o_protocol_code,
  input wire logic [2:0] o_protocol_family
);
  logic [2:0] en_hist = 3'h0;
  wire w0 = i_wr && i_enable && (&en_hist) && i_addr == 8'h00;
  wire w1 = i_wr && i_enable && (&en_hist) && i_addr == 8'h01;
  always @(posedge i_clock) en_hist <= {en_hist[1:0], i_enable};
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  mode_wr_a:
  assert property (w0 |-> ##2 {o_standby, o_direct_mode, o_tx_on, o_half_power, o_aux_rx_sel,
    o_supply_5v} == {$past(i_wdata[7:3], 2), $past(i_wdata[0], 2)}) else $error("mode");
  rx_force_a:
  assert property (w0 && i_wdata[1] |-> ##2 o_rx_on && o_osc_on) else $error("force");
  rx_auto_a:
  assert property (w0 && !i_wdata[1] |-> ##2 o_rx_on == $past(i_wdata[5], 2)) else $error("auto");
  proto_wr_a:
  assert property (w1 |-> ##2 {o_crc_present, o_raw_mode_type, 1'b0, o_protocol_code}
    == (($past(i_wdata, 2) & 8'hdf) ^ 8'h80)) else $error("proto");
  opt_reload_a:
  assert property (w1 |=> o_option_reload) else $error("reload");
  family_map_a:
  assert property (o_protocol_family == (o_protocol_code < 5'h08 ? 3'h0 : o_protocol_code < 5'h0c
    ? 3'h1 : o_protocol_code < 5'h10 ? 3'h2 : o_protocol_code[4:1] == 4'hd ? 3'h3 : 3'h4))
    else $error("family");
  enable_reset_a:
  assert property (!i_enable [*4] |=> o_protocol_code == 5'h02 && o_supply_5v && !o_tx_on)
    else $error("enable");
  rsvd_bit_a:
  assert property (i_rd && i_addr == 8'h00 |=> o_rvalid && !o_rdata[2]) else $error("bit2");
  standby_ready_a:
  assert property (o_standby |-> !o_ready) else $error("ready");
endmodule
bind reader_main_control_regs ctrl_regs_monitor mon_u (.*);
`default_nettype wire

//--- dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic i_clock = 0, i_nrst = 0, i_enable = 1;
  wire i_wr, i_rd, o_rvalid, o_standby, o_ready, o_direct_mode, o_raw_mode_type, o_tx_on;
  wire o_rx_on, o_osc_on, o_half_power, o_aux_rx_sel, o_supply_5v, o_crc_present;
  wire o_option_reload;
  wire [7:0] i_addr, i_wdata, o_rdata;
  wire [4:0] o_protocol_code;
  wire [2:0] o_protocol_family;
  wire [1:0] o_protocol_rate;
  int n_mismatch = 0, cmp_count = 0, seed = 77, n;
  logic [7:0] exp_q[$], d;
  always #5 i_clock = ~i_clock;
  host_model host_u (.i_clock(i_clock), .o_wr(i_wr), .o_rd(i_rd), .o_addr(i_addr),
    .o_wdata(i_wdata));
  reader_main_control_regs dut_u (.*);
  task chk(input string nm, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task tally_and_finish;
    if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input logic [7:0] a, v);
    host_u.access(1'b1, a, v);
  endtask
  task rd(input logic [7:0] a, e);
    exp_q.push_back(e);
    host_u.access(1'b0, a, 8'h00);
  endtask
  always @(negedge i_clock) if (o_rvalid === 1'b1) begin
    chk("rdata", o_rdata, exp_q.pop_front());
  end
  initial begin
    #200000;
    n_mismatch++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(negedge i_clock);
    i_nrst = 1;
    repeat (3) @(negedge i_clock);
    rd(8'h00, 8'h01);
    rd(8'h01, 8'h02);
    rd(8'h07, 8'h00);
    for (n = 0; n < 8; n++) begin
      d = $random(seed);
      wr(8'h00, d & 8'hbf);
      rd(8'h00, d & 8'hbb);
      wr(8'h01, d);
      rd(8'h01, d & 8'hdf);
    end
    wr(8'h01, 8'h42);
    wr(8'h00, 8'h60);
    for (n = 0; n < 32; n++) begin
      wr(8'h01, n[7:0]);
      @(negedge i_clock);
      chk("family", o_protocol_family, n < 8 ? 0 : n < 12 ? 1 : n < 16 ? 2 : n / 2 == 13 ? 3 : 4);
      chk("rate", {6'h00, o_protocol_rate}, {6'h00, n[1:0]});
    end
    i_enable = 0;
    repeat (5) @(negedge i_clock);
    wr(8'h00, 8'h20);
    i_enable = 1;
    repeat (3) @(negedge i_clock);
    rd(8'h00, 8'h01);
    rd(8'h01, 8'h02);
    wr(8'h00, 8'h81);
    wr(8'h00, 8'h01);
    for (n = 0; n < 20000 && o_ready !== 1'b1; n++) @(negedge i_clock);
    chk("wake", n > 9990 && n < 10010, 1);
    tally_and_finish;
  end
endmodule
`default_nettype wire
